// *** hw/smr_serial_message_recognizer.v ***
// Purpose: collects serial bytes into messages, keeps last and temporary copies
// Assumes: rxValid marks one received byte per pulse, synchronous to clk
// Notes:   registers over Avalon-MM, one wait state per access
//
// Functional notes
// [RULE_01] capture bytes while enabled, close on terminator/idle
// [RULE_02] terminator up to eight bytes, programmable length
// [RULE_03] terminator closes message, including terminator bytes
// [RULE_04] idle gap closes message without terminator
// [RULE_05] idle gap in ms, 0 off, minimum 10
// [RULE_06] keep first twelve bytes as text
// [RULE_07] keep message also as ascii hex
// [RULE_08] keep 32-bit fingerprint of message
// [RULE_09] persistent copies hold until next message or clear
// [RULE_10] clear erases every stored copy
// [RULE_11] temporary copy erased after active lifetime
// [RULE_12] lifetime programmable 0 to 255 ms
// [RULE_13] lifetime resets to 50 ms
// [RULE_14] persistent change flag silent on repeats
// [RULE_15] temporary change flag fires on every repeat; code fires it only when the temporary copy is empty
// [RULE_16] fingerprint is CRC-32, updated per byte
// [RULE_17] 1 ms tick drives idle and lifetime counters
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`include "smr_regs.vh"

module smr_serial_message_recognizer #(
    parameter MS_CYCLES = `SMR_CLK_HZ / 1000 * `SMR_TICK_MS
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // avalon-mm slave
    input  wire [7:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // received serial bytes
    input  wire [7:0]  rxData,
    input  wire        rxValid,
    // interrupt
    output wire        irq
);

    // last count of one millisecond
    localparam integer MS_LAST_I = MS_CYCLES - 1;
    localparam [17:0]  MS_LAST   = MS_LAST_I[17:0];

    // reflected crc-32, lsb first
    function [31:0] crcByte;
        input [31:0] c;
        input [7:0]  d;
        integer      k;
        reg   [31:0] x;
        begin
            x = c ^ {24'h00_0000, d};
            for (k = 0; k < 8; k = k + 1) begin
                x = x[0] ? ((x >> 1) ^ `SMR_CRC_POLY) : (x >> 1);
            end
            crcByte = x;
        end
    endfunction

    // nibble to upper-case ascii
    function [7:0] hexChar;
        input [3:0] n;
        begin
            hexChar = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
        end
    endfunction

    // two bytes per word, high nibble character first
    function [31:0] hexWord;
        input [95:0] t;
        input [15:0] len;
        input [2:0]  w;
        integer      k;
        integer      idx;
        reg   [7:0]  b;
        begin
            hexWord = 32'h0000_0000;
            for (k = 0; k < 2; k = k + 1) begin
                idx = 2 * w + k;
                b = t[8*idx +: 8];
                if (idx < len) begin
                    hexWord[16*k +: 16] = {hexChar(b[3:0]), hexChar(b[7:4])};
                end
            end
        end
    endfunction

    // lanes with enable low keep old
    function [31:0] applyBe;
        input [31:0] old;
        input [31:0] val;
        input [3:0]  be;
        integer      k;
        begin
            applyBe = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    applyBe[8*k +: 8] = val[8*k +: 8];
                end
            end
        end
    endfunction

    // configuration and status
    reg         capEnable;
    reg  [63:0] termPattern;
    reg  [3:0]  termLen;
    reg  [15:0] idleMs;
    reg  [7:0]  lifeMs;
    reg  [3:0]  irqStatus;
    reg  [3:0]  irqMask;
    reg         ack;

    // collection
    reg  [95:0] collectText;
    reg  [15:0] msgLen;
    reg  [31:0] collectCrc;
    reg  [63:0] history;
    reg  [15:0] idleAge;

    // stored copies
    reg  [95:0] lastText;
    reg  [15:0] lastLen;
    reg  [31:0] lastFp;
    reg  [95:0] tempText;
    reg  [15:0] tempLen;
    reg  [31:0] tempFp;
    reg  [7:0]  tempAge;

    reg  [17:0] msCount;
    wire        msTick = (msCount == MS_LAST);

    // bus strobes
    assign waitrequest = (read | write) & ~ack;
    wire   wrStb = write & ack;
    wire   clrReq = wrStb & (address == `SMR_OFF_CTRL) & byteenable[0] & writedata[`SMR_CTRL_CLR];

    // byte acceptance and next collection values
    wire        byteIn = rxValid & capEnable;
    wire [15:0] nextLen = (msgLen == 16'hFFFF) ? msgLen : (msgLen + 16'h0001);
    wire [31:0] nextCrc = crcByte(collectCrc, rxData);
    wire [63:0] nextHist = {history[55:0], rxData};
    reg  [95:0] nextText;
    integer     i;

    // bytes past twelve are not stored
    always @* begin
        nextText = collectText;
        for (i = 0; i < `SMR_TEXT_BYTES; i = i + 1) begin
            if (msgLen == i) begin
                nextText[8*i +: 8] = rxData;                         // [RULE_06]
            end
        end
    end

    // per-byte terminator comparison
    wire [7:0] byteHit;
    genvar     g;
    generate
        for (g = 0; g < `SMR_TERM_BYTES; g = g + 1) begin : gTerm
            assign byteHit[g] = (g >= termLen) | (nextHist[8*g +: 8] == termPattern[8*g +: 8]); // [RULE_02]
        end
    endgenerate

    // close on terminator or idle gap
    wire termHit = byteIn & (termLen != 4'h0) & (nextLen >= {12'h000, termLen}) & (&byteHit); // [RULE_01] [RULE_03]
    wire idleHit = ~byteIn & (msgLen != 16'h0000) & (idleMs != 16'h0000) & (idleAge >= idleMs); // [RULE_04] [RULE_05]
    wire save = termHit | idleHit;

    wire [95:0] saveText = termHit ? nextText : collectText;
    wire [15:0] saveLen = termHit ? nextLen : msgLen;
    wire [31:0] saveFp = termHit ? ~nextCrc : ~collectCrc;           // [RULE_08] [RULE_16]

    // change flags for both copies
    wire lastChg = save & ((saveLen != lastLen) | (saveFp != lastFp) | (saveText != lastText)); // [RULE_14]
    wire tempChg = save & ((tempLen == 16'h0000) | (saveLen != tempLen) | (saveFp != tempFp) |
                           (saveText != tempText));                  // [RULE_15]
    wire tempExp = (tempLen != 16'h0000) & (tempAge >= lifeMs) & ~save; // [RULE_11]

    wire [3:0] events;
    assign events[`SMR_STAT_SAVED] = save;
    assign events[`SMR_STAT_TEMP_EXP] = tempExp;
    assign events[`SMR_STAT_LAST_CHG] = lastChg;
    assign events[`SMR_STAT_TEMP_CHG] = tempChg;

    // w1c status, set wins
    wire [3:0] w1c = (wrStb & (address == `SMR_OFF_STAT) & byteenable[0]) ? writedata[3:0] : 4'h0;
    assign irq = |(irqStatus & irqMask);

    // millisecond time base
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msCount <= 18'h0_0000;
        end else if (msTick) begin
            msCount <= 18'h0_0000;                                   // [RULE_17]
        end else begin
            msCount <= msCount + 18'h0_0001;
        end
    end

    // configuration writes
    wire [31:0] idleNew = applyBe({16'h0000, idleMs}, writedata, byteenable);
    wire [31:0] lifeNew = applyBe({24'h00_0000, lifeMs}, writedata, byteenable);
    wire [31:0] lenNew = applyBe({28'h000_0000, termLen}, writedata, byteenable);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capEnable <= 1'b0;
            termPattern <= 64'h0000_0000_0000_0000;
            termLen <= 4'h0;
            idleMs <= `SMR_IDLE_RST;
            lifeMs <= `SMR_LIFE_RST;                                 // [RULE_13]
            irqMask <= 4'h0;
            irqStatus <= 4'h0;
        end else begin
            irqStatus <= (irqStatus & ~w1c) | events;
            if (wrStb) begin
                case (address)
                    `SMR_OFF_CTRL: begin
                        if (byteenable[0]) begin
                            capEnable <= writedata[`SMR_CTRL_EN];
                        end
                    end
                    `SMR_OFF_TERM_LO: begin
                        termPattern[31:0] <= applyBe(termPattern[31:0], writedata, byteenable);
                    end
                    `SMR_OFF_TERM_HI: begin
                        termPattern[63:32] <= applyBe(termPattern[63:32], writedata, byteenable);
                    end
                    `SMR_OFF_TERM_LEN: begin
                        termLen <= (lenNew > 32'h0000_0008) ? `SMR_TERM_LEN_MAX : lenNew[3:0]; // [RULE_02]
                    end
                    `SMR_OFF_IDLE: begin
                        if (idleNew[15:0] != 16'h0000 && idleNew[15:0] < `SMR_IDLE_MIN) begin
                            idleMs <= `SMR_IDLE_MIN;                 // [RULE_05]
                        end else begin
                            idleMs <= idleNew[15:0];
                        end
                    end
                    `SMR_OFF_LIFE: begin
                        lifeMs <= lifeNew[7:0];                      // [RULE_12]
                    end
                    `SMR_OFF_MASK: begin
                        if (byteenable[0]) begin
                            irqMask <= writedata[3:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // message collection and idle gap
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            collectText <= 96'h0;
            msgLen <= 16'h0000;
            collectCrc <= `SMR_CRC_INIT;
            history <= 64'h0000_0000_0000_0000;
            idleAge <= 16'h0000;
        end else if (clrReq || save) begin
            collectText <= 96'h0;                                    // [RULE_03]
            msgLen <= 16'h0000;
            collectCrc <= `SMR_CRC_INIT;
            history <= byteIn ? nextHist : history;
            idleAge <= 16'h0000;
        end else if (byteIn) begin
            collectText <= nextText;                                 // [RULE_01]
            msgLen <= nextLen;
            collectCrc <= nextCrc;                                   // [RULE_16]
            history <= nextHist;
            idleAge <= 16'h0000;                                     // [RULE_17]
        end else if (msTick && idleAge != 16'hFFFF) begin
            idleAge <= idleAge + 16'h0001;
        end
    end

    // persistent and temporary copies
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastText <= 96'h0;
            lastLen <= 16'h0000;
            lastFp <= 32'h0000_0000;
            tempText <= 96'h0;
            tempLen <= 16'h0000;
            tempFp <= 32'h0000_0000;
            tempAge <= 8'h00;
        end else if (clrReq) begin
            // clear beats a same-cycle save
            lastText <= 96'h0;                                       // [RULE_10]
            lastLen <= 16'h0000;
            lastFp <= 32'h0000_0000;
            tempText <= 96'h0;
            tempLen <= 16'h0000;
            tempFp <= 32'h0000_0000;
            tempAge <= 8'h00;
        end else if (save) begin
            lastText <= saveText;                                    // [RULE_09]
            lastLen <= saveLen;
            lastFp <= saveFp;
            tempText <= saveText;                                    // [RULE_11]
            tempLen <= saveLen;
            tempFp <= saveFp;
            tempAge <= 8'h00;                                        // [RULE_17]
        end else if (tempExp) begin
            tempText <= 96'h0;                                       // [RULE_11]
            tempLen <= 16'h0000;
            tempFp <= 32'h0000_0000;
            tempAge <= 8'h00;
        end else if (msTick && tempLen != 16'h0000 && tempAge != 8'hFF) begin
            tempAge <= tempAge + 8'h01;
        end
    end

    // read path
    wire [7:0] offLastTxt = address - `SMR_OFF_LAST_TXT;
    wire [7:0] offLastHex = address - `SMR_OFF_LAST_HEX;
    wire [7:0] offTempTxt = address - `SMR_OFF_TEMP_TXT;
    wire [7:0] offTempHex = address - `SMR_OFF_TEMP_HEX;
    reg  [31:0] rdMux;

    // unlisted offsets read zero
    always @* begin
        rdMux = 32'h0000_0000;
        case (address)
            `SMR_OFF_CTRL:     rdMux = {31'h0, capEnable};
            `SMR_OFF_TERM_LO:  rdMux = termPattern[31:0];
            `SMR_OFF_TERM_HI:  rdMux = termPattern[63:32];
            `SMR_OFF_TERM_LEN: rdMux = {28'h000_0000, termLen};
            `SMR_OFF_IDLE:     rdMux = {16'h0000, idleMs};
            `SMR_OFF_LIFE:     rdMux = {24'h00_0000, lifeMs};
            `SMR_OFF_STAT:     rdMux = {28'h000_0000, irqStatus};
            `SMR_OFF_MASK:     rdMux = {28'h000_0000, irqMask};
            `SMR_OFF_LAST_LEN: rdMux = {16'h0000, lastLen};
            `SMR_OFF_LAST_FP:  rdMux = lastFp;
            `SMR_OFF_TEMP_LEN: rdMux = {16'h0000, tempLen};
            `SMR_OFF_TEMP_FP:  rdMux = tempFp;
            default: begin
                if (address >= `SMR_OFF_LAST_TXT && address < `SMR_OFF_LAST_HEX) begin
                    rdMux = lastText[32*offLastTxt[3:2] +: 32];
                end else if (address >= `SMR_OFF_LAST_HEX && address < `SMR_OFF_TEMP_LEN) begin
                    rdMux = hexWord(lastText, lastLen, offLastHex[4:2]); // [RULE_07]
                end else if (address >= `SMR_OFF_TEMP_TXT && address < `SMR_OFF_TEMP_HEX) begin
                    rdMux = tempText[32*offTempTxt[3:2] +: 32];
                end else if (address >= `SMR_OFF_TEMP_HEX && address < `SMR_OFF_END) begin
                    rdMux = hexWord(tempText, tempLen, offTempHex[4:2]); // [RULE_07]
                end
            end
        endcase
    end

    // exactly one wait state per access
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            ack <= (read | write) & ~ack;
            if (read && !ack) begin
                readdata <= rdMux;
            end
        end
    end

endmodule // smr_serial_message_recognizer

// *** include/smr_regs.vh ***
// Purpose: register map, field positions, reset values and timing of the recognizer
// Assumes: byte addresses on an 8-bit Avalon-MM address
// Notes:   text words hold received bytes, lowest byte first
`ifndef SMR_REGS_VH
`define SMR_REGS_VH

// timing
`define SMR_CLK_HZ        200000000
`define SMR_TICK_MS       1

// offsets
`define SMR_OFF_CTRL      8'h00
`define SMR_OFF_TERM_LO   8'h04
`define SMR_OFF_TERM_HI   8'h08
`define SMR_OFF_TERM_LEN  8'h0C
`define SMR_OFF_IDLE      8'h10
`define SMR_OFF_LIFE      8'h14
`define SMR_OFF_STAT      8'h18
`define SMR_OFF_MASK      8'h1C
`define SMR_OFF_LAST_LEN  8'h20
`define SMR_OFF_LAST_FP   8'h24
`define SMR_OFF_LAST_TXT  8'h28
`define SMR_OFF_LAST_HEX  8'h34
`define SMR_OFF_TEMP_LEN  8'h4C
`define SMR_OFF_TEMP_FP   8'h50
`define SMR_OFF_TEMP_TXT  8'h54
`define SMR_OFF_TEMP_HEX  8'h60
`define SMR_OFF_END       8'h78

// fields
`define SMR_CTRL_EN       0
`define SMR_CTRL_CLR      1
`define SMR_STAT_SAVED    0
`define SMR_STAT_TEMP_EXP 1
`define SMR_STAT_LAST_CHG 2
`define SMR_STAT_TEMP_CHG 3

// sizes and reset values
`define SMR_TEXT_BYTES    12
`define SMR_TERM_BYTES    8
`define SMR_TERM_LEN_MAX  4'h8
`define SMR_IDLE_RST      16'h0000
`define SMR_IDLE_MIN      16'h000A
`define SMR_LIFE_RST      8'h32
`define SMR_CRC_INIT      32'hFFFF_FFFF
`define SMR_CRC_POLY      32'hEDB8_8320

`endif

// *** verif/smr_checker.sv ***
// Purpose: port-level assertions for the serial message recognizer
// Assumes: one wait state per access, master holds requests until accepted
// Notes:   erased tracks clear requests and reset until an enabled byte arrives
`include "smr_regs.vh"
module smr_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // avalon-mm slave
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // received bytes and interrupt
    input wire logic [7:0]  rxData,
    input wire logic        rxValid,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic wrAcc;
    logic inHex;
    logic hexOk;
    logic enShadow;
    logic erased;
    logic lifeKept;
    function automatic logic hexc(input logic [7:0] c);
        return c == 8'h00 || (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction
    assign acc = read && !waitrequest;
    assign wrAcc = write && !waitrequest && byteenable[0];
    assign inHex = (address >= `SMR_OFF_LAST_HEX && address < `SMR_OFF_TEMP_LEN) || address >= `SMR_OFF_TEMP_HEX;
    assign hexOk = hexc(readdata[7:0]) && hexc(readdata[15:8]) && hexc(readdata[23:16]) && hexc(readdata[31:24]);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enShadow <= 1'b0;
            erased   <= 1'b1;
            lifeKept <= 1'b1;
        end else begin
            if (wrAcc && address == `SMR_OFF_CTRL)
                enShadow <= writedata[0];
            if (rxValid && enShadow)
                erased <= 1'b0;
            else if (wrAcc && address == `SMR_OFF_CTRL && writedata[1])
                erased <= 1'b1;
            if (wrAcc && address == `SMR_OFF_LIFE)
                lifeKept <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_term_len_max; acc && address == `SMR_OFF_TERM_LEN |-> readdata <= 32'h0000_0008; endproperty
    a_term_len_max: assert property (p_term_len_max) else $error("terminator length above eight");
    property p_idle_range; acc && address == `SMR_OFF_IDLE |-> readdata[31:16] == 16'h0000
        && (readdata[15:0] == 16'h0000 || readdata[15:0] >= `SMR_IDLE_MIN); endproperty
    a_idle_range: assert property (p_idle_range) else $error("idle limit out of range");
    property p_hex_chars; acc && inHex && address < `SMR_OFF_END |-> hexOk; endproperty
    a_hex_chars: assert property (p_hex_chars) else $error("hex copy holds a non-hex character");
    property p_life_width; acc && address == `SMR_OFF_LIFE |-> readdata[31:8] == 24'h00_0000; endproperty
    a_life_width: assert property (p_life_width) else $error("lifetime wider than eight bits");
    property p_life_reset; acc && address == `SMR_OFF_LIFE && lifeKept |-> readdata == {24'h00_0000, `SMR_LIFE_RST};
    endproperty
    a_life_reset: assert property (p_life_reset) else $error("lifetime not at reset value");
    property p_clear_last; acc && erased && address >= `SMR_OFF_LAST_LEN && address < `SMR_OFF_TEMP_LEN
        |-> readdata == 32'h0000_0000; endproperty
    a_clear_last: assert property (p_clear_last) else $error("persistent copy not erased");
    property p_clear_temp; acc && erased && address >= `SMR_OFF_TEMP_LEN && address < `SMR_OFF_END
        |-> readdata == 32'h0000_0000; endproperty
    a_clear_temp: assert property (p_clear_temp) else $error("temporary copy not erased");
    property p_unmapped; acc && address >= `SMR_OFF_END |-> readdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address reads nonzero");
    property p_wait_single; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_wait_single: assert property (p_wait_single) else $error("more than one wait state");
    property p_wait_rearm; (read || write) && !waitrequest |=> waitrequest || !(read || write); endproperty
    a_wait_rearm: assert property (p_wait_rearm) else $error("back to back access without wait state");
    cover property (rxValid && enShadow);
    cover property ($rose(irq));
    cover property (acc && erased && address == `SMR_OFF_LAST_LEN);
endmodule // smr_checker

bind smr_serial_message_recognizer smr_checker smr_checker_inst (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rxData(rxData), .rxValid(rxValid), .irq(irq));

// *** verif/smr_byte_source.sv ***
// Purpose: model of the serial equipment, hands received bytes to the recognizer
// Assumes: one valid pulse per byte, any spacing
// Notes:   data line shows the inverse of the last byte when idle
module smr_byte_source (
    // clock
    input wire logic  clk,
    // byte stream
    output logic [7:0] rxData,
    output logic       rxValid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rxData = 8'h00;
        rxValid = 1'b0;
    end
    // gap 0 sends a byte every cycle
    task automatic sendMsg(input logic [7:0] m[$], input int gap);
        foreach (m[i]) begin
            @(posedge clk);
            rxData <= m[i];
            rxValid <= 1'b1;
            if (gap > 0) begin
                @(posedge clk);
                rxValid <= 1'b0;
                rxData <= ~m[i];
                repeat (gap - 1) @(posedge clk);
            end
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxData <= ~m[m.size() - 1];
    endtask
endmodule // smr_byte_source

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the serial message recognizer
// Assumes: millisecond tick shortened to 20 clock cycles
// Notes:   registers over avalon-mm, bytes from smr_byte_source
`include "smr_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 20;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [7:0]  rxData;
    logic        rxValid;
    logic        irq;
    logic [31:0] rd;
    logic [7:0]  msg[$];
    int          nFail = 0;
    int          nTests = 0;
    always #2.5 clk = ~clk;
    smr_serial_message_recognizer #(.MS_CYCLES(MS)) smr_serial_message_recognizer_inst (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .rxData(rxData), .rxValid(rxValid), .irq(irq));
    smr_byte_source smr_byte_source_inst (.clk(clk), .rxData(rxData), .rxValid(rxValid));
    task automatic results;
        $display("comparisons %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            nFail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic waitAck;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            nFail++;
            results();
        end
        rd = readdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        waitAck();
        write <= 1'b0;
    endtask
    task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp,
                         input logic [31:0] mask = 32'hFFFF_FFFF);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        waitAck();
        read <= 1'b0;
        check(name, exp & mask, rd & mask);
    endtask
    task automatic irqChk(input logic exp);
        @(negedge clk);
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask
    function automatic logic [7:0] hc(input logic [3:0] n);
        return (n < 10) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // compares length, crc, text and hex of one copy against msg
    task automatic chkMsg(input bit t);
        logic [31:0] c;
        logic [31:0] e;
        logic [31:0] m;
        int b;
        c = `SMR_CRC_INIT;
        foreach (msg[i]) begin
            c = c ^ {24'h00_0000, msg[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `SMR_CRC_POLY : c >> 1;
        end
        rdChk("length", t ? `SMR_OFF_TEMP_LEN : `SMR_OFF_LAST_LEN, 32'(msg.size()));
        rdChk("fingerprint", t ? `SMR_OFF_TEMP_FP : `SMR_OFF_LAST_FP, ~c);
        for (int w = 0; w < 3; w++) begin
            e = 32'h0000_0000;
            m = 32'h0000_0000;
            for (int k = 0; k < 4; k++) begin
                b = 4 * w + k;
                if (b < msg.size()) begin
                    e[8*k +: 8] = msg[b];
                    m[8*k +: 8] = 8'hFF;
                end
            end
            rdChk("text", (t ? `SMR_OFF_TEMP_TXT : `SMR_OFF_LAST_TXT) + 8'(4 * w), e, m);
        end
        for (int w = 0; w < 6; w++) begin
            e = 32'h0000_0000;
            for (int k = 0; k < 2; k++) begin
                b = 2 * w + k;
                if (b < msg.size())
                    e[16*k +: 16] = {hc(msg[b][3:0]), hc(msg[b][7:4])};
            end
            rdChk("hex", (t ? `SMR_OFF_TEMP_HEX : `SMR_OFF_LAST_HEX) + 8'(4 * w), e);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdChk("lifetime reset", `SMR_OFF_LIFE, 32'h0000_0032);
        rdChk("idle reset", `SMR_OFF_IDLE, 32'h0000_0000);
        wr(`SMR_OFF_END, 32'hFFFF_FFFF);
        rdChk("unmapped", `SMR_OFF_END, 32'h0000_0000);
        wr(`SMR_OFF_MASK, 32'h0000_000F);
        wr(`SMR_OFF_TERM_LEN, 32'h0000_0009);
        rdChk("terminator length", `SMR_OFF_TERM_LEN, 32'h0000_0008);
        wr(`SMR_OFF_TERM_LEN, 32'h0000_0001);
        wr(`SMR_OFF_TERM_LO, 32'hFFFF_FF3A, 4'h1);
        rdChk("terminator lanes", `SMR_OFF_TERM_LO, 32'h0000_003A);
        wr(`SMR_OFF_TERM_HI, 32'h1234_5678);
        rdChk("pattern high", `SMR_OFF_TERM_HI, 32'h1234_5678);
        msg = '{8'h4C, 8'h6F, 8'h3A};
        smr_byte_source_inst.sendMsg(msg, 0);
        rdChk("disabled", `SMR_OFF_LAST_LEN, 32'h0000_0000);
        wr(`SMR_OFF_CTRL, 32'h0000_0001);
        smr_byte_source_inst.sendMsg(msg, 2);
        chkMsg(0);
        chkMsg(1);
        rdChk("status first", `SMR_OFF_STAT, 32'h0000_000D, 32'h0000_000D);
        irqChk(1'b1);
        wr(`SMR_OFF_MASK, 32'h0000_0000);
        irqChk(1'b0);
        wr(`SMR_OFF_MASK, 32'h0000_000F);
        wr(`SMR_OFF_STAT, 32'h0000_000F);
        irqChk(1'b0);
        smr_byte_source_inst.sendMsg(msg, 0);
        rdChk("status repeat", `SMR_OFF_STAT, 32'h0000_0001, 32'h0000_000D);
        wr(`SMR_OFF_LIFE, 32'h0000_0003);
        wr(`SMR_OFF_STAT, 32'h0000_000F);
        repeat (3 * MS + 10) @(posedge clk);
        rdChk("temp expired", `SMR_OFF_TEMP_LEN, 32'h0000_0000);
        rdChk("expiry flag", `SMR_OFF_STAT, 32'h0000_0002, 32'h0000_0002);
        rdChk("last held", `SMR_OFF_LAST_LEN, 32'h0000_0003);
        wr(`SMR_OFF_STAT, 32'h0000_000F);
        smr_byte_source_inst.sendMsg(msg, 0);
        rdChk("status reload", `SMR_OFF_STAT, 32'h0000_0009, 32'h0000_000D);
        rdChk("temp alive", `SMR_OFF_TEMP_LEN, 32'h0000_0003);
        wr(`SMR_OFF_TERM_LEN, 32'h0000_0002);
        wr(`SMR_OFF_TERM_LO, 32'h0000_0D0A);
        msg = '{8'h30, 8'h0A, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h41, 8'h42, 8'h0D, 8'h0A};
        smr_byte_source_inst.sendMsg(msg, 0);
        chkMsg(0);
        wr(`SMR_OFF_TERM_LEN, 32'h0000_0000);
        wr(`SMR_OFF_IDLE, 32'h0000_0005);
        rdChk("idle clamp", `SMR_OFF_IDLE, 32'h0000_000A);
        msg = '{8'h41, 8'h42};
        smr_byte_source_inst.sendMsg(msg, 3);
        repeat (8 * MS) @(posedge clk);
        rdChk("idle early", `SMR_OFF_LAST_LEN, 32'h0000_000E);
        repeat (3 * MS) @(posedge clk);
        chkMsg(0);
        wr(`SMR_OFF_IDLE, 32'h0000_0000);
        msg.push_back(8'h43);
        smr_byte_source_inst.sendMsg(msg, 0);
        repeat (15 * MS) @(posedge clk);
        rdChk("idle off", `SMR_OFF_LAST_LEN, 32'h0000_0002);
        wr(`SMR_OFF_CTRL, 32'h0000_0003);
        msg.delete();
        chkMsg(0);
        chkMsg(1);
        results();
    end
endmodule // tb_top
